// >>> src/lpsc_regs.sv
// APB register bank for the bus transceiver and start-up configuration
`timescale 1ns/100ps
`default_nettype none
module lpsc_regs
  import lpsc_pkg::*;
#(
  parameter int DOM_CYC = LPSC_DOM_FAIL_CYC // Stuck-dominant limit
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip context
  input  wire logic        chip_normal_or_flash,
  input  wire logic        bus_transmit_pin,
  input  wire logic        bus_receive_pin,
  input  wire logic [11:0] gp1_feedback,
  input  wire logic [11:0] irq_enable_feedback,
  // Transceiver controls
  output logic             bus_active_enable,
  output logic             slope_select,
  output logic             drive_boost_select,
  output logic             transmitter_enable,
  // Start-up controls
  output logic             dev_mode_init,
  output logic [1:0]       watchdog_prescale,
  output logic [2:0]       watchdog_factor_x2,
  output logic [1:0]       supply_reset_threshold,
  output logic [6:0]       supply_threshold_pct
);
  // Held control words, reserved bits always zero
  // Reserved bits are dropped on the way in, so the
  // feedback never shows a one the host cannot set
  logic [11:0] lin_phy_control;   // Transceiver control
  logic [11:0] startup_config;    // Start-up configuration
  logic [15:0] response;          // Last frame answer
  logic        iface_fail;        // Failure-induced disable
  logic        frame_unknown;     // Last frame had an unused select
  logic [7:0]  frame_count;       // Frames handled since reset or the last status clear

  // Decoder and monitor results
  // Both helpers are pure or self-resetting, so the
  // bank owns every piece of architectural state
  lpsc_tgt_t   dec_target;        // Addressed register
  logic        dec_write;         // Frame stores payload
  logic [11:0] dec_readback;      // Selected feedback word
  logic        fail_event;        // Failure detected this cycle
  logic        good_traffic;      // Healthy traffic seen

  // Bus phase terms
  // Decoded once here so every store sees the same
  // completion edge and no path can act twice
  logic        acc;               // Access phase, answer not yet given
  logic        done;              // Edge at which the transfer completes
  logic        wr_frame;          // Completed frame write
  logic        wr_clr;            // Completed status clear write
  logic [15:0] frame;             // Frame carried by the write
  logic        txd_new;           // Disable bit after a control write
  logic [11:0] next_phy;          // Control word after a write

  // Watchdog factor in halves, used for the watchdog_factor_x2 output only
  // Halves keep the factor an integer; the watchdog
  // divides by two where it applies the period
  function automatic logic [2:0] wd_factor(input logic [1:0] code);
    case (code)
      2'h0:    wd_factor = LPSC_WDF_00;
      2'h1:    wd_factor = LPSC_WDF_01;
      2'h2:    wd_factor = LPSC_WDF_10;
      default: wd_factor = LPSC_WDF_11;
    endcase
  endfunction

  // Threshold in percent; codes 00 and 11 both mean 0.9
  // Percent rather than a fraction keeps the supply
  // comparator free of any divider
  function automatic logic [6:0] thr_pct(input logic [1:0] code);
    case (code)
      2'h1:    thr_pct = LPSC_THR_80;
      2'h2:    thr_pct = LPSC_THR_70;
      default: thr_pct = LPSC_THR_90;
    endcase
  endfunction

  // Mapped offsets, used by the error logic
  // The read mux decodes the same offsets except the clear offset
  // in its own if chain and returns zero for every other offset
  function automatic logic mapped(input logic [7:0] a);
    if (a == LPSC_FRAME_OFF) begin
      mapped = 1'b1;
    end else if (a == LPSC_PHY_OFF) begin
      mapped = 1'b1;
    end else if (a == LPSC_CFG_OFF) begin
      mapped = 1'b1;
    end else if (a == LPSC_STATUS_OFF) begin
      mapped = 1'b1;
    end else if (a == LPSC_CLR_OFF) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction

  // Frame decode
  // The decoder sees the held words, not the words a
  // write is about to store, which gives the answer
  // its one-frame-behind shift-register behaviour
  lpsc_frame_dec u_dec (
    .frame     (frame),
    .phy_fb    (lin_phy_control),
    .cfg_fb    (startup_config),
    .gp1_fb    (gp1_feedback),
    .irq_en_fb (irq_enable_feedback),
    .target    (dec_target),
    .do_write  (dec_write),
    .readback  (dec_readback)
  );

  // Interface level monitor
  // Watches the controller pins; a jammed transmit
  // pin is reported as a single-cycle failure event
  // and healthy receive edges as recovery events
  lpsc_iface_mon #(
    .DOM_CYC (DOM_CYC)
  ) u_mon (
    .mclk             (mclk),
    .rst_b            (rst_b),
    .bus_transmit_pin (bus_transmit_pin),
    .bus_receive_pin  (bus_receive_pin),
    .fail_event       (fail_event),
    .good_traffic     (good_traffic)
  );

  // Transfer completes one cycle into the access phase
  // pready is registered, so the first access cycle
  // only prepares the answer and the second one is
  // the edge at which writes take effect
  always_comb begin
    acc      = psel && penable && !pready;
    done     = psel && penable && pready;
    wr_frame = done && pwrite && (paddr == LPSC_FRAME_OFF);
    wr_clr   = done && pwrite && (paddr == LPSC_CLR_OFF);
    frame    = pwdata[15:0];
  end

  // Control word a write would leave; reserved bits forced low
  // The failure clear compares this against the held
  // disable bit to spot a one-to-zero step
  always_comb begin
    next_phy = frame[11:0] & LPSC_PHY_MASK;
    txd_new  = next_phy[LPSC_TXD_BIT];
  end

  // One wait state so read data always comes from a flop
  // Costs one cycle per transfer but keeps the read
  // mux out of the bus timing path
  // Back-to-back transfers are still accepted
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= acc;
    end
  end

  // Unmapped offsets answer with an error, never stall
  // Raised together with pready so a master sees both
  // flags at the same completing edge
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc && !mapped(paddr);
    end
  end

  // Read data latched with the answer
  // Captured in the preparing cycle, so the word is
  // stable for the whole cycle in which pready stands
  // Upper bits of every register read back as zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (acc && !pwrite) begin
      if (paddr == LPSC_FRAME_OFF) begin
        prdata <= {16'h0000, response};
      end else if (paddr == LPSC_PHY_OFF) begin
        prdata <= {20'h00000, lin_phy_control};
      end else if (paddr == LPSC_CFG_OFF) begin
        prdata <= {20'h00000, startup_config};
      end else if (paddr == LPSC_STATUS_OFF) begin
        prdata <= {16'h0000, frame_count, 4'h0,
                   frame_unknown, chip_normal_or_flash, transmitter_enable, iface_fail};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end else if (acc) begin
      // Writes read back as zero
      prdata <= 32'h0000_0000;
    end
  end

  // Answer captures the feedback held before this frame's write
  // A host must send one more frame to see what it
  // just wrote; the select and flags are echoed so
  // software can match an answer to its frame
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      response <= 16'h0000;
    end else if (wr_frame) begin
      response <= {frame[15:12], dec_readback};
    end
  end

  // Transceiver control store
  // Only complete frames with the no-write flag clear
  // and the control select may change it
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lin_phy_control <= LPSC_PHY_RST;
    end else if (wr_frame && dec_write && dec_target == LPSC_TGT_PHY) begin
      lin_phy_control <= next_phy;
    end
  end

  // Start-up configuration store, reserved bits dropped
  // Meant for start-up; later writes are accepted
  // too and take effect one cycle after the store
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      startup_config <= LPSC_CFG_RST;
    end else if (wr_frame && dec_write && dec_target == LPSC_TGT_CFG) begin
      startup_config <= frame[11:0] & LPSC_CFG_MASK;
    end
  end

  // Failure-induced disable; a new failure wins over any clear
  // Set priority only covers the single failure pulse; a pin that
  // stays jammed does not pulse again, so a software clear re-enables it
  // The stored disable bit is left untouched
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      iface_fail <= 1'b0;
    end else if (fail_event) begin
      iface_fail <= 1'b1;
    end else if (good_traffic) begin
      iface_fail <= 1'b0;
    end else if (wr_frame && dec_write && dec_target == LPSC_TGT_PHY
                 && lin_phy_control[LPSC_TXD_BIT] && !txd_new) begin
      // Disable bit taken from one to zero by software
      iface_fail <= 1'b0;
    end
  end

  // Frame bookkeeping for software diagnosis
  // The count wraps at 255; software reads it as a
  // progress marker, not as an exact total
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      frame_unknown <= 1'b0;
      frame_count   <= 8'h00;
    end else if (wr_frame) begin
      frame_unknown <= (dec_target == LPSC_TGT_NONE);
      frame_count   <= frame_count + 8'h01;
    end else if (wr_clr && pwdata[0]) begin
      frame_unknown <= 1'b0;
      frame_count   <= 8'h00;
    end
  end

  // Active mode needs both the bit and a permitting chip mode
  // Leaving the permitting mode drops active mode one
  // cycle later, with no write needed from the host
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bus_active_enable <= 1'b0;
    end else begin
      bus_active_enable <= lin_phy_control[LPSC_ACT_BIT] && chip_normal_or_flash;
    end
  end

  // Slope and drive strength follow their bits directly
  // Registered so the analog side sees no decode glitch
  // while a frame is being stored
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      slope_select       <= 1'b0;
      drive_boost_select <= 1'b0;
    end else begin
      slope_select       <= lin_phy_control[LPSC_SLP_BIT];
      drive_boost_select <= lin_phy_control[LPSC_DRV_BIT];
    end
  end

  // Transmitter runs only with bit clear and no failure pending
  // Reset leaves it off; it comes on one cycle after
  // reset is released if nothing is pending
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      transmitter_enable <= 1'b0;
    end else begin
      transmitter_enable <= !lin_phy_control[LPSC_TXD_BIT] && !iface_fail;
    end
  end

  // Start-up parameters, decoded once here for the consumers
  // Raw codes and decoded values both leave the block
  // so each consumer can take whichever form it needs
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dev_mode_init          <= 1'b0;
      watchdog_prescale      <= 2'h0;
      watchdog_factor_x2     <= LPSC_WDF_00;
      supply_reset_threshold <= 2'h0;
      supply_threshold_pct   <= LPSC_THR_90;
    end else begin
      dev_mode_init          <= startup_config[LPSC_DEV_BIT];
      watchdog_prescale      <= startup_config[LPSC_WDP_LO +: 2];
      watchdog_factor_x2     <= wd_factor(startup_config[LPSC_WDP_LO +: 2]);
      supply_reset_threshold <= startup_config[LPSC_THR_LO +: 2];
      supply_threshold_pct   <= thr_pct(startup_config[LPSC_THR_LO +: 2]);
    end
  end
endmodule
`default_nettype wire

// >>> src/lpsc_pkg.sv
// Constants and types shared by the bus transceiver and start-up register bank
package lpsc_pkg;
  // APB byte offsets of the bank
  localparam logic [7:0] LPSC_FRAME_OFF  = 8'h00; // Frame in, response out
  localparam logic [7:0] LPSC_PHY_OFF    = 8'h04; // Transceiver control view
  localparam logic [7:0] LPSC_CFG_OFF    = 8'h08; // Start-up config view
  localparam logic [7:0] LPSC_STATUS_OFF = 8'h0c; // Live status
  localparam logic [7:0] LPSC_CLR_OFF    = 8'h10; // Status clear strobes

  // Frame field positions
  localparam int LPSC_SEL_HI  = 15; // Register select, upper bit
  localparam int LPSC_SEL_LO  = 14; // Register select, lower bit
  localparam int LPSC_RBS_BIT = 13; // Readback select
  localparam int LPSC_NOW_BIT = 12; // No-write flag
  localparam int LPSC_DATA_W  = 12; // Payload width

  // Register select codes
  localparam logic [1:0] LPSC_SEL_PHY = 2'h3; // Transceiver control
  localparam logic [1:0] LPSC_SEL_CFG = 2'h1; // Start-up configuration

  // Transceiver control field positions
  localparam int LPSC_ACT_BIT = 4; // Active-mode enable
  localparam int LPSC_SLP_BIT = 3; // Low slope
  localparam int LPSC_DRV_BIT = 2; // Drive boost
  localparam int LPSC_TXD_BIT = 0; // Transmitter disable
  localparam logic [11:0] LPSC_PHY_MASK = 12'h01d; // Writable bits

  // Start-up configuration field positions
  localparam int LPSC_DEV_BIT = 9; // Development mode init
  localparam int LPSC_WDP_LO  = 5; // Watchdog prescale, low bit
  localparam int LPSC_THR_LO  = 3; // Supply threshold, low bit
  localparam logic [11:0] LPSC_CFG_MASK = 12'h278; // Writable bits

  // Reset values
  localparam logic [11:0] LPSC_PHY_RST = 12'h000;
  localparam logic [11:0] LPSC_CFG_RST = 12'h000;

  // Watchdog factor in halves: 1, 1.5, 2.5, 3.5
  localparam logic [2:0] LPSC_WDF_00 = 3'h2;
  localparam logic [2:0] LPSC_WDF_01 = 3'h3;
  localparam logic [2:0] LPSC_WDF_10 = 3'h5;
  localparam logic [2:0] LPSC_WDF_11 = 3'h7;

  // Supply threshold in percent of nominal
  localparam logic [6:0] LPSC_THR_90 = 7'h5a;
  localparam logic [6:0] LPSC_THR_80 = 7'h50;
  localparam logic [6:0] LPSC_THR_70 = 7'h46;

  // Dominant time on the transmit pin that flags a failure
  localparam int LPSC_DOM_FAIL_US = 12;
  localparam int LPSC_CLK_MHZ     = 250;
  localparam int LPSC_DOM_FAIL_CYC = LPSC_DOM_FAIL_US * LPSC_CLK_MHZ;

  // Target of a frame
  typedef enum logic [1:0] {LPSC_TGT_NONE, LPSC_TGT_PHY, LPSC_TGT_CFG} lpsc_tgt_t;
endpackage

// >>> src/lpsc_iface_mon.sv
// Watches the controller-side transmit and receive pins for level failures
`timescale 1ns/100ps
`default_nettype none
module lpsc_iface_mon
  import lpsc_pkg::*;
#(
  parameter int DOM_CYC = LPSC_DOM_FAIL_CYC // Stuck-dominant limit
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic bus_transmit_pin,   // Low is dominant request
  input  wire logic bus_receive_pin,    // Bus state seen by the transceiver
  output logic      fail_event,         // One-cycle failure pulse
  output logic      good_traffic        // One-cycle pulse on healthy edge
);
  logic [$clog2(DOM_CYC+1)-1:0] dom_cnt; // Dominant run length
  logic rx_prev;                         // Receive level last cycle

  // Count a transmit pin stuck low; a stuck pin would jam the bus
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dom_cnt    <= '0;
      fail_event <= 1'b0;
    end else begin
      fail_event <= 1'b0;
      if (bus_transmit_pin) begin
        dom_cnt <= '0;
      end else if (dom_cnt != DOM_CYC[$bits(dom_cnt)-1:0]) begin
        dom_cnt <= dom_cnt + 1'b1;
        fail_event <= (dom_cnt == DOM_CYC[$bits(dom_cnt)-1:0] - 1'b1);
      end
    end
  end

  // A falling receive edge while transmit is recessive is real traffic
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_prev      <= 1'b1;
      good_traffic <= 1'b0;
    end else begin
      rx_prev      <= bus_receive_pin;
      good_traffic <= rx_prev && !bus_receive_pin && bus_transmit_pin;
    end
  end
endmodule
`default_nettype wire

// >>> src/lpsc_frame_dec.sv
// Decodes an access frame into a target, a write enable and readback data
`timescale 1ns/100ps
`default_nettype none
module lpsc_frame_dec
  import lpsc_pkg::*;
(
  input  wire logic [15:0] frame,       // Frame from the host
  input  wire logic [11:0] phy_fb,      // Transceiver control feedback
  input  wire logic [11:0] cfg_fb,      // Start-up config feedback
  input  wire logic [11:0] gp1_fb,      // General purpose feedback 1
  input  wire logic [11:0] irq_en_fb,   // Interrupt enable feedback
  output lpsc_tgt_t        target,      // Register addressed
  output logic             do_write,    // Frame stores its payload
  output logic [11:0]      readback     // Word returned to the host
);
  logic [1:0] sel;  // Register select bits
  logic       rbs;  // Readback select

  // Pure decode; the caller registers the results
  always_comb begin
    sel      = frame[LPSC_SEL_HI:LPSC_SEL_LO];
    rbs      = frame[LPSC_RBS_BIT];
    target   = LPSC_TGT_NONE;
    readback = 12'h000;
    if (sel == LPSC_SEL_PHY) begin
      target   = LPSC_TGT_PHY;
      readback = rbs ? gp1_fb : phy_fb;
    end else if (sel == LPSC_SEL_CFG) begin
      target   = LPSC_TGT_CFG;
      readback = rbs ? cfg_fb : irq_en_fb;
    end
    // No-write frames only read back
    do_write = (target != LPSC_TGT_NONE) && !frame[LPSC_NOW_BIT];
  end
endmodule
`default_nettype wire

// >>> verification/lpsc_regs_properties.sv
// Port checker for the transceiver and start-up register bank
`timescale 1ns/100ps
`default_nettype none
module lpsc_regs_properties
  import lpsc_pkg::*;
#(
  parameter int DOM_CYC = LPSC_DOM_FAIL_CYC // Stuck-dominant limit
) (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       chip_normal_or_flash,
  input wire logic       bus_transmit_pin,
  input wire logic       bus_active_enable,
  input wire logic       transmitter_enable,
  input wire logic [1:0] watchdog_prescale,
  input wire logic [2:0] watchdog_factor_x2,
  input wire logic [1:0] supply_reset_threshold,
  input wire logic [6:0] supply_threshold_pct
);
  int         low_cnt; // Consecutive dominant cycles
  logic       mapped;  // Address hits a register
  logic [2:0] wdf_exp; // Factor for the prescale code
  logic [6:0] pct_exp; // Threshold for the threshold code

  // Counts dominant time; a recessive cycle restarts it
  always_ff @(posedge mclk) begin
    if (!rst_b || bus_transmit_pin) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  // Expected factor, independent of the design's decoding
  always_comb begin
    case (watchdog_prescale)
      2'h0: wdf_exp = LPSC_WDF_00;
      2'h1: wdf_exp = LPSC_WDF_01;
      2'h2: wdf_exp = LPSC_WDF_10;
      default: wdf_exp = LPSC_WDF_11;
    endcase
  end
  // Codes 00 and 11 share the top threshold
  assign pct_exp = (supply_reset_threshold == 2'h1) ? LPSC_THR_80 :
                   (supply_reset_threshold == 2'h2) ? LPSC_THR_70 : LPSC_THR_90;
  assign mapped = paddr inside {LPSC_FRAME_OFF, LPSC_PHY_OFF, LPSC_CFG_OFF, LPSC_STATUS_OFF, LPSC_CLR_OFF};

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  a_ready_needs_access: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access phase");
  a_error_on_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match address decode");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error flag outside a completing cycle");
  a_active_mode_gate: assert property (bus_active_enable |-> $past(chip_normal_or_flash))
    else $error("active mode outside normal or flash");
  a_wdog_factor_map: assert property (watchdog_factor_x2 == wdf_exp)
    else $error("watchdog factor does not match prescale code");
  a_threshold_map: assert property (supply_threshold_pct == pct_exp)
    else $error("threshold does not match threshold code");
  a_fail_disables_tx: assert property (low_cnt == DOM_CYC + 3 |-> !transmitter_enable)
    else $error("transmitter still on after stuck dominant");

  c_unmapped: cover property (pready && pslverr);
  c_stuck: cover property (low_cnt == DOM_CYC + 3);
  c_active: cover property (bus_active_enable);
endmodule

bind lpsc_regs lpsc_regs_properties #(.DOM_CYC(DOM_CYC)) u_props (.*);
`default_nettype wire

// >>> verification/lpsc_lin_ctrl_model.sv
// Behavioural bus controller and far node facing the transceiver pins
`timescale 1ns/100ps
`default_nettype none
module lpsc_lin_ctrl_model (
  input wire logic mclk,
  input wire logic stuck,              // Hold transmit dominant
  input wire logic traffic,            // A far node sends a frame
  input wire logic transmitter_enable,
  output var logic bus_transmit_pin,
  output var logic bus_receive_pin
);
  logic [1:0] ph = 2'h0; // Bit phase of the far node

  initial begin
    bus_transmit_pin = 1'b1;
    bus_receive_pin = 1'b1;
  end

  // Pins change just after an edge; idle bus reads recessive
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    bus_transmit_pin <= !stuck;
    if (stuck) begin
      // Own dominant is seen only while the driver is on
      bus_receive_pin <= !transmitter_enable;
    end else if (traffic) begin
      bus_receive_pin <= ph[1];
    end else begin
      bus_receive_pin <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/lin_phy_and_start_config_regs_test.sv
// Self-checking bench for the transceiver and start-up register bank
`timescale 1ns/100ps
`default_nettype none
module lin_phy_and_start_config_regs_test;
  import lpsc_pkg::*;
  localparam int DOM = 20; // Short failure limit keeps the run brief
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        chip_normal_or_flash = 1'b1;
  logic        stuck = 1'b0;
  logic        traffic = 1'b0;
  logic        tx_pin;
  logic        rx_pin;
  logic        act, slope, boost, tx_en, dev;
  logic [1:0]  wdp, thr;
  logic [2:0]  wdf;
  logic [6:0]  pct;
  logic [31:0] rdat;
  logic        rerr;
  logic [11:0] p;
  logic [11:0] q = 12'h0;
  logic [2:0]  wdf_tab [4] = '{LPSC_WDF_00, LPSC_WDF_01, LPSC_WDF_10, LPSC_WDF_11};
  logic [6:0]  pct_tab [4] = '{LPSC_THR_90, LPSC_THR_80, LPSC_THR_70, LPSC_THR_90};
  int          miscompares = 0;
  int          compares = 0;

  always #2 mclk = ~mclk;

  lpsc_regs #(.DOM_CYC(DOM)) uut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_normal_or_flash(chip_normal_or_flash), .bus_transmit_pin(tx_pin),
    .bus_receive_pin(rx_pin), .gp1_feedback(12'h5a5), .irq_enable_feedback(12'h3c3),
    .bus_active_enable(act), .slope_select(slope), .drive_boost_select(boost),
    .transmitter_enable(tx_en), .dev_mode_init(dev), .watchdog_prescale(wdp),
    .watchdog_factor_x2(wdf), .supply_reset_threshold(thr), .supply_threshold_pct(pct)
  );

  lpsc_lin_ctrl_model far (
    .mclk(mclk), .stuck(stuck), .traffic(traffic), .transmitter_enable(tx_en),
    .bus_transmit_pin(tx_pin), .bus_receive_pin(rx_pin)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stalled wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(rdat, e);
    check({31'h0, rerr}, {31'h0, ee});
  endtask

  // Send a frame, then fetch its response word
  task automatic frm(input logic [15:0] f, input logic [15:0] e);
    apb(1'b1, LPSC_FRAME_OFF, {16'h0, f});
    rd(LPSC_FRAME_OFF, {16'h0, e}, 1'b0);
  endtask

  // Transceiver outputs: active, slope, boost, transmitter
  task automatic outs(input logic [3:0] e);
    check({28'h0, act, slope, boost, tx_en}, {28'h0, e});
  endtask

  // Stuck dominant long enough to trip, then released quietly
  task automatic fail();
    stuck <= 1'b1;
    repeat (DOM + 6) @(posedge mclk);
    outs(4'h0);
    stuck <= 1'b0;
    repeat (4) @(posedge mclk);
    outs(4'h0);
  endtask

  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    check({25'h0, pct}, {25'h0, LPSC_THR_90});
    check({29'h0, wdf}, {29'h0, LPSC_WDF_00});
    outs(4'h1);
    rd(LPSC_PHY_OFF, 32'h0, 1'b0);
    rd(LPSC_CFG_OFF, 32'h0, 1'b0);
    frm(16'hc01c, 16'hc000);
    outs(4'hf);
    rd(LPSC_PHY_OFF, 32'h01c, 1'b0);
    frm(16'hd000, 16'hd01c);
    rd(LPSC_PHY_OFF, 32'h01c, 1'b0);
    frm(16'hf000, 16'hf5a5);
    chip_normal_or_flash <= 1'b0;
    frm(16'hd000, 16'hd01c);
    outs(4'h7);
    frm(16'hc001, 16'hc01c);
    outs(4'h0);
    frm(16'hc000, 16'hc001);
    outs(4'h1);
    // Failure leaves the stored bit alone; far traffic heals it
    fail();
    rd(LPSC_PHY_OFF, 32'h0, 1'b0);
    traffic <= 1'b1;
    repeat (16) @(posedge mclk);
    outs(4'h1);
    traffic <= 1'b0;
    // A bare zero does not heal; one then zero does
    fail();
    apb(1'b1, LPSC_CLR_OFF, 32'h1);
    rd(LPSC_STATUS_OFF, 32'h1, 1'b0);
    frm(16'hc000, 16'hc000);
    outs(4'h0);
    frm(16'hc001, 16'hc000);
    frm(16'hc000, 16'hc001);
    outs(4'h1);
    // Every prescale and threshold code
    for (int i = 0; i < 4; i++) begin
      p = {2'h0, i[0], 2'h0, i[1:0], i[1:0], 3'h0};
      frm({4'h6, p}, {4'h6, q});
      q = p;
      check({27'h0, dev, wdp, thr}, {27'h0, i[0], i[1:0], i[1:0]});
      check({22'h0, wdf, pct}, {22'h0, wdf_tab[i], pct_tab[i]});
      rd(LPSC_CFG_OFF, {20'h0, p}, 1'b0);
    end
    frm(16'h5000, 16'h53c3);
    rd(LPSC_CFG_OFF, {20'h0, q}, 1'b0);
    // Other select codes touch nothing
    frm(16'h8fff, 16'h8000);
    frm(16'h0fff, 16'h0000);
    rd(LPSC_PHY_OFF, 32'h0, 1'b0);
    rd(LPSC_CFG_OFF, {20'h0, q}, 1'b0);
    rd(LPSC_STATUS_OFF, 32'ha0a, 1'b0);
    apb(1'b1, LPSC_CLR_OFF, 32'h1);
    rd(LPSC_STATUS_OFF, 32'h2, 1'b0);
    // Read-only view and an unmapped address
    apb(1'b1, LPSC_PHY_OFF, 32'hfff);
    check({31'h0, rerr}, 32'h0);
    rd(LPSC_PHY_OFF, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
